// *** rtl/multi_pwm_consts.vh ***
/*
 * Constants of the two-output PWM timer block: register offsets,
 * control bit positions, reset values and the count clock divider.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MULTI_PWM_CONSTS_VH
`define MULTI_PWM_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_UNIT_CTRL 8'h00
`define OFS_TRIGGER 8'h04
`define OFS_ENABLE_STATUS 8'h08
`define OFS_OUTPUT_CTRL 8'h0C
`define OFS_CHANNEL_MODE0 8'h10
`define OFS_CHANNEL_MODE1 8'h14
`define OFS_CHANNEL_MODE2 8'h18
`define OFS_PERIOD_DATA 8'h20
`define OFS_DUTY_DATA1 8'h24
`define OFS_DUTY_DATA2 8'h28
`define OFS_COUNT0 8'h30
`define OFS_COUNT1 8'h34
`define OFS_COUNT2 8'h38
`define OFS_CHANNEL_STATUS0 8'h40
`define OFS_CHANNEL_STATUS1 8'h44
`define OFS_CHANNEL_STATUS2 8'h48

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define BIT_UNIT_POWER 0
`define BIT_START_LO 0
`define BIT_STOP_LO 4
`define BIT_OEN1 0
`define BIT_OEN2 1
`define BIT_OLVL1 4
`define BIT_OLVL2 5
`define BIT_OPOL1 8
`define BIT_OPOL2 9
`define BIT_OMODE1 12
`define BIT_OMODE2 13

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define COUNT_RESET 16'h0000
`define DATA_RESET 16'h0000
`define MODE_RESET 16'h0000
`define PRESCALE_RESET 8'h00
`define OFS_PRESCALE 8'h1C

`endif

// *** rtl/multi_pwm_timer.v ***
/*
 * Two-output PWM timer: one master channel sets the period, two slave
 * channels set the duty; registers reached over AHB-Lite.
 * Assumes single word transfers from one AHB-Lite master on hclk.
 */
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "multi_pwm_consts.vh"

// Notes on behaviour
// - All three count registers are readable at any time.
// - Channel status registers are unused and read as zero.
// - On start the master loads its period and counts down per tick.
// - At master zero raise the event, reload the period, keep counting.
// - First slave loads its duty on every master event, then counts down.
// - First slave output goes active one count clock after the event.
// - First slave goes inactive at zero and stops until the next event.
// - Second slave loads its own duty on each master event.
// - Second slave active one tick after event, inactive and stopped at zero.
// - Stop trigger bits clear themselves and read back as zero.
// - Stop clears enable status, halts counting, freezes count registers.
// - Stopping leaves both slave output levels unchanged.
// - With output enable clear, each pin follows its software output level.
// - Power enable cleared resets all channel registers and returns pins to port.
// - Master start raises the period event at once, starting both slaves.
// - Start trigger bits fire together and clear themselves.
module multi_pwm_timer #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Pins and events
    output reg [1:0] pwm_out,
    output reg [1:0] pin_timer_mode,
    output reg master_period_irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg unit_power_enable;
    reg [7:0] prescale_reg;
    reg [7:0] div_reg;
    reg tick;
    reg [2:0] channel_enable_status;
    reg [1:0] slave_output_enable;
    reg [1:0] slave_output_level;
    reg [1:0] output_polarity_bit;
    reg [1:0] output_mode_bit;
    reg [WIDTH-1:0] channel_mode_reg0;
    reg [WIDTH-1:0] channel_mode_reg1;
    reg [WIDTH-1:0] channel_mode_reg2;
    reg [WIDTH-1:0] period_data_reg;
    reg [WIDTH-1:0] duty_data_reg1;
    reg [WIDTH-1:0] duty_data_reg2;
    reg [WIDTH-1:0] count_reg0;
    reg period_evt;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [31:0] rd_next;
    wire [WIDTH-1:0] count_reg1;
    wire [WIDTH-1:0] count_reg2;
    wire [1:0] slave_active;
    wire clr_unit;
    wire wr_now;
    wire start_wr;
    wire stop_wr;
    wire addr_phase;

    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_now = wr_pend;
    assign clr_unit = !unit_power_enable;
    assign start_wr = wr_now && !clr_unit && (wr_addr == `OFS_TRIGGER) && (hwdata[`BIT_START_LO +: 3] != 3'h0);
    assign stop_wr = wr_now && !clr_unit && (wr_addr == `OFS_TRIGGER) && (hwdata[`BIT_STOP_LO +: 3] != 3'h0);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always @* begin
        rd_next = 32'h0000_0000;
        case (haddr)
            `OFS_UNIT_CTRL: rd_next[`BIT_UNIT_POWER] = unit_power_enable;
            `OFS_TRIGGER: rd_next = 32'h0000_0000;
            `OFS_ENABLE_STATUS: rd_next[2:0] = channel_enable_status;
            `OFS_OUTPUT_CTRL: begin
                rd_next[`BIT_OEN1] = slave_output_enable[0];
                rd_next[`BIT_OEN2] = slave_output_enable[1];
                rd_next[`BIT_OLVL1] = slave_output_level[0];
                rd_next[`BIT_OLVL2] = slave_output_level[1];
                rd_next[`BIT_OPOL1] = output_polarity_bit[0];
                rd_next[`BIT_OPOL2] = output_polarity_bit[1];
                rd_next[`BIT_OMODE1] = output_mode_bit[0];
                rd_next[`BIT_OMODE2] = output_mode_bit[1];
            end
            `OFS_CHANNEL_MODE0: rd_next[WIDTH-1:0] = channel_mode_reg0;
            `OFS_CHANNEL_MODE1: rd_next[WIDTH-1:0] = channel_mode_reg1;
            `OFS_CHANNEL_MODE2: rd_next[WIDTH-1:0] = channel_mode_reg2;
            `OFS_PRESCALE: rd_next[7:0] = prescale_reg;
            `OFS_PERIOD_DATA: rd_next[WIDTH-1:0] = period_data_reg;
            `OFS_DUTY_DATA1: rd_next[WIDTH-1:0] = duty_data_reg1;
            `OFS_DUTY_DATA2: rd_next[WIDTH-1:0] = duty_data_reg2;
            `OFS_COUNT0: rd_next[WIDTH-1:0] = count_reg0;
            `OFS_COUNT1: rd_next[WIDTH-1:0] = count_reg1;
            `OFS_COUNT2: rd_next[WIDTH-1:0] = count_reg2;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr <= haddr;
            end
            if (addr_phase && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_power_enable <= 1'b0;
            prescale_reg <= `PRESCALE_RESET;
            slave_output_enable <= 2'h0;
            slave_output_level <= 2'h0;
            output_polarity_bit <= 2'h0;
            output_mode_bit <= 2'h0;
            channel_mode_reg0 <= `MODE_RESET;
            channel_mode_reg1 <= `MODE_RESET;
            channel_mode_reg2 <= `MODE_RESET;
            period_data_reg <= `DATA_RESET;
            duty_data_reg1 <= `DATA_RESET;
            duty_data_reg2 <= `DATA_RESET;
        end else begin
            if (wr_now && wr_addr == `OFS_UNIT_CTRL) begin
                unit_power_enable <= hwdata[`BIT_UNIT_POWER];
            end
            if (clr_unit) begin
                prescale_reg <= `PRESCALE_RESET;
                slave_output_enable <= 2'h0;
                slave_output_level <= 2'h0;
                output_polarity_bit <= 2'h0;
                output_mode_bit <= 2'h0;
                channel_mode_reg0 <= `MODE_RESET;
                channel_mode_reg1 <= `MODE_RESET;
                channel_mode_reg2 <= `MODE_RESET;
                period_data_reg <= `DATA_RESET;
                duty_data_reg1 <= `DATA_RESET;
                duty_data_reg2 <= `DATA_RESET;
            end else if (wr_now) begin
                case (wr_addr)
                    `OFS_OUTPUT_CTRL: begin
                        slave_output_enable <= {hwdata[`BIT_OEN2], hwdata[`BIT_OEN1]};
                        slave_output_level <= {hwdata[`BIT_OLVL2], hwdata[`BIT_OLVL1]};
                        output_polarity_bit <= {hwdata[`BIT_OPOL2], hwdata[`BIT_OPOL1]};
                        output_mode_bit <= {hwdata[`BIT_OMODE2], hwdata[`BIT_OMODE1]};
                    end
                    `OFS_CHANNEL_MODE0: channel_mode_reg0 <= hwdata[WIDTH-1:0];
                    `OFS_CHANNEL_MODE1: channel_mode_reg1 <= hwdata[WIDTH-1:0];
                    `OFS_CHANNEL_MODE2: channel_mode_reg2 <= hwdata[WIDTH-1:0];
                    `OFS_PRESCALE: prescale_reg <= hwdata[7:0];
                    `OFS_PERIOD_DATA: period_data_reg <= hwdata[WIDTH-1:0];
                    `OFS_DUTY_DATA1: duty_data_reg1 <= hwdata[WIDTH-1:0];
                    `OFS_DUTY_DATA2: duty_data_reg2 <= hwdata[WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Count clock divider
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 8'h00;
            tick <= 1'b0;
        end else if (clr_unit) begin
            div_reg <= 8'h00;
            tick <= 1'b0;
        end else if (start_wr) begin
            // A start restarts the divider phase so the first tick lands one count clock later.
            div_reg <= 8'h01;
            tick <= (prescale_reg == 8'h00);
        end else if (div_reg >= prescale_reg) begin
            div_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 8'h01;
            tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Master channel
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_enable_status <= 3'h0;
            count_reg0 <= `COUNT_RESET;
            period_evt <= 1'b0;
            master_period_irq <= 1'b0;
        end else if (clr_unit) begin
            channel_enable_status <= 3'h0;
            count_reg0 <= `COUNT_RESET;
            period_evt <= 1'b0;
            master_period_irq <= 1'b0;
        end else begin
            master_period_irq <= 1'b0;
            if (stop_wr) begin
                channel_enable_status <= 3'h0;
                period_evt <= 1'b0;
            end else if (start_wr) begin
                channel_enable_status <= 3'h7;
                count_reg0 <= period_data_reg;
                period_evt <= 1'b1;
                master_period_irq <= 1'b1;
            end else if (channel_enable_status[0] && tick) begin
                // The first tick after a start decrements just as the first tick after a reload does.
                period_evt <= 1'b0;
                if (count_reg0 == `COUNT_RESET) begin
                    count_reg0 <= period_data_reg;
                    period_evt <= 1'b1;
                    master_period_irq <= 1'b1;
                end else begin
                    count_reg0 <= count_reg0 - 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Slave channels and pins
    // ------------------------------------------------------------
    pwm_slave_channel #(.WIDTH(WIDTH)) u_slave1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(clr_unit),
        .run(channel_enable_status[1]),
        .tick(tick),
        .period_evt(period_evt),
        .duty(duty_data_reg1),
        .count_reg(count_reg1),
        .active_reg(slave_active[0])
    );

    pwm_slave_channel #(.WIDTH(WIDTH)) u_slave2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(clr_unit),
        .run(channel_enable_status[2]),
        .tick(tick),
        .period_evt(period_evt),
        .duty(duty_data_reg2),
        .count_reg(count_reg2),
        .active_reg(slave_active[1])
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= 2'h0;
            pin_timer_mode <= 2'h0;
        end else begin
            pin_timer_mode <= {2{unit_power_enable}};
            pwm_out <= (slave_active ^ output_polarity_bit) & slave_output_enable
                       | slave_output_level & ~slave_output_enable;
        end
    end

endmodule // multi_pwm_timer

`default_nettype wire

// *** rtl/pwm_slave_channel.v ***
/*
 * One slave channel of the two-output PWM timer: loads its duty value on
 * the master period event, drives its output active, counts down on the
 * count enable and returns inactive at zero.
 * Assumes a single clock, and that clr resets it when the unit is powered off.
 */
`timescale 1ns/1ps
`default_nettype none
`include "multi_pwm_consts.vh"

module pwm_slave_channel #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    input wire clr,
    // Control
    input wire run,
    input wire tick,
    input wire period_evt,
    input wire [WIDTH-1:0] duty,
    // State
    output reg [WIDTH-1:0] count_reg,
    output reg active_reg
);

    reg counting_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `COUNT_RESET;
            active_reg <= 1'b0;
            counting_reg <= 1'b0;
        end else if (clr) begin
            count_reg <= `COUNT_RESET;
            active_reg <= 1'b0;
            counting_reg <= 1'b0;
        end else if (run && tick) begin
            if (period_evt) begin
                count_reg <= duty;
                counting_reg <= 1'b1;
                active_reg <= 1'b1;
            end else if (counting_reg) begin
                if (count_reg == `COUNT_RESET) begin
                    active_reg <= 1'b0;
                    counting_reg <= 1'b0;
                end else begin
                    count_reg <= count_reg - 1'b1;
                    if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                        active_reg <= 1'b0;
                        counting_reg <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // pwm_slave_channel

`default_nettype wire

// *** test/multi_pwm_timer_props.sv ***
/*
 * Checker for the two-output PWM timer: bus answers, event pulse and pin hand-over.
 * Assumes it is bound to multi_pwm_timer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module multi_pwm_timer_props #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Pins
    input wire [1:0] pwm_out,
    input wire [1:0] pin_timer_mode,
    input wire master_period_irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready;
    reg pwr_wr_reg;
    reg stp_wr_reg;

    // ------------------------------------------------------------
    // Data phase trackers
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_wr_reg <= 1'b0;
            stp_wr_reg <= 1'b0;
        end else begin
            pwr_wr_reg <= take && hwrite && haddr == 8'h00;
            stp_wr_reg <= take && hwrite && haddr == 8'h04;
        end
    end

    ready_always_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    status_zero_a: assert property (take && !hwrite && haddr inside {8'h40, 8'h44, 8'h48} |=> hrdata == 32'h0)
        else $error("status register read not zero");
    trig_selfclear_a: assert property (take && !hwrite && haddr == 8'h04 |=> hrdata == 32'h0)
        else $error("trigger register read not zero");
    unmapped_zero_a: assert property (take && !hwrite && haddr == 8'hFC |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    irq_pulse_a: assert property (master_period_irq |=> !master_period_irq)
        else $error("period event longer than one cycle");
    irq_powered_a: assert property (master_period_irq |-> pin_timer_mode == 2'b11)
        else $error("period event while unit off");
    power_off_a: assert property (pwr_wr_reg && !hwdata[0] |-> ##3 pin_timer_mode == 2'b00 && pwm_out == 2'b00)
        else $error("power off left pins in timer mode");
    stop_quiet_a: assert property (stp_wr_reg && hwdata[6:4] != 3'b000 |-> ##2 !master_period_irq [*8])
        else $error("period event after stop");
    modes_match_a: assert property (pin_timer_mode[0] == pin_timer_mode[1])
        else $error("pin modes differ");
endmodule // multi_pwm_timer_props

bind multi_pwm_timer multi_pwm_timer_props #(.WIDTH(WIDTH)) u_multi_pwm_timer_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pwm_out(pwm_out), .pin_timer_mode(pin_timer_mode), .master_period_irq(master_period_irq));

`default_nettype wire

// *** test/multi_pwm_timer_tb.sv ***
/*
 * Self-checking bench for the two-output PWM timer.
 * Assumes zero wait state AHB-Lite answers and a tick on every clock.
 */
`timescale 1ns/1ps
`default_nettype none

module multi_pwm_timer_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, master_period_irq;
    logic [7:0] haddr;
    logic [1:0] htrans, pwm_out, pin_timer_mode;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, rd2;
    int mismatches = 0;
    int n_checks = 0;
    int n, h0, h1;

    multi_pwm_timer #(.WIDTH(16)) u_multi_pwm_timer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pwm_out(pwm_out), .pin_timer_mode(pin_timer_mode), .master_period_irq(master_period_irq));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd2);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, rd);
        chk(what, exp, rd);
    endtask

    task automatic wait_irq;
        n = 0;
        while (master_period_irq !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk("irq seen", 32'h1, 32'(master_period_irq));
    endtask

    // Counts the cycles of one period and the high cycles of each pin.
    task automatic measure;
        wait_irq();
        n = 0;
        h0 = 0;
        h1 = 0;
        do begin
            @(posedge hclk);
            n++;
            h0 += pwm_out[0];
            h1 += pwm_out[1];
        end while (master_period_irq !== 1'b1 && n < 100);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("pins", 32'h0, {pin_timer_mode, pwm_out});
        wr(8'h20, 32'h5);
        rd_chk("period while off", 8'h20, 32'h0);
        rd_chk("unmapped", 8'hFC, 32'h0);
    endtask

    task automatic t_run;
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h7);
        wr(8'h24, 32'h2);
        wr(8'h28, 32'h4);
        wr(8'h0C, 32'h3203);
        wr(8'h04, 32'h7);
        rd_chk("trigger read", 8'h04, 32'h0);
        rd_chk("enable status", 8'h08, 32'h7);
        for (int i = 0; i < 3; i++) rd_chk("status", 8'h40 + 8'(4 * i), 32'h0);
        measure();
        chk("period", 32'd8, 32'(n));
        chk("slave1 width", 32'd2, 32'(h0));
        chk("slave2 width", 32'd8 - 32'd4, 32'(h1));
        xfer(1'b0, 8'h30, 32'h0, rd);
        chk("count0 range", 32'h1, 32'(rd <= 32'h7));
    endtask

    task automatic t_update;
        wait_irq();
        wr(8'h24, 32'h5);
        measure();
        chk("updated width", 32'd5, 32'(h0));
        chk("slave2 kept", 32'd8 - 32'd4, 32'(h1));
    endtask

    task automatic t_stop;
        wait_irq();
        repeat (2) @(posedge hclk);
        wr(8'h04, 32'h70);
        rd_chk("enable after stop", 8'h08, 32'h0);
        xfer(1'b0, 8'h30, 32'h0, rd);
        xfer(1'b0, 8'h34, 32'h0, rd2);
        h0 = pwm_out;
        repeat (10) @(posedge hclk);
        rd_chk("count frozen", 8'h30, rd);
        rd_chk("count1 frozen", 8'h34, rd2);
        chk("outputs held", 32'(h0), 32'(pwm_out));
    endtask

    task automatic t_handover;
        wr(8'h0C, 32'h3210);
        repeat (2) @(posedge hclk);
        chk("pin levels a", 32'h1, 32'(pwm_out));
        wr(8'h0C, 32'h3220);
        repeat (2) @(posedge hclk);
        chk("pin levels b", 32'h2, 32'(pwm_out));
    endtask

    task automatic t_poweroff;
        wr(8'h00, 32'h0);
        repeat (3) @(posedge hclk);
        chk("pins off", 32'h0, {pin_timer_mode, pwm_out});
        rd_chk("outputs cleared", 8'h0C, 32'h0);
        rd_chk("period cleared", 8'h20, 32'h0);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_run();
        t_update();
        t_stop();
        t_handover();
        t_poweroff();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end
endmodule // multi_pwm_timer_tb

`default_nettype wire
